//--- rtl/irq_clear_consts.svh
/*
  Constants for the interrupt clear and identification register bank:
  register offsets, bit positions, reset values and ident defaults.
  Assumes inclusion by the package and design files via bare name.
*/
// Operation
// [R1] Writing one to clear bit 7 clears framing error interrupt; zero does nothing.
// [R2] Writing one to clear bit 6 clears receive time-out interrupt; zero nothing.
// [R3] Writing one to clear bit 5 clears transmit interrupt; zero leaves it.
// [R4] Writing one to clear bit 4 clears receive interrupt; zero leaves it.
// [R5] Software ignores reserved bits and preserves them in read-modify-write.
// [R6] Ident registers 0xfd0/0xfd4/0xfd8 return fixed ident bytes 0, 1, 2.
// [R7] A clear removes both raw and masked status of that source.
// [R8] Clear register sits at 0x044, write-one-to-clear, reads zero.
`ifndef IRQ_CLEAR_CONSTS_SVH
`define IRQ_CLEAR_CONSTS_SVH

`define OFS_RAW_STATUS 12'h03c
`define OFS_MASK 12'h038
`define OFS_MASKED_STATUS 12'h040
`define OFS_INTERRUPT_CLEAR 12'h044
`define OFS_EVENT_SET 12'h048
`define OFS_IDENT_BYTE_FOUR 12'hfd0
`define OFS_IDENT_BYTE_FIVE 12'hfd4
`define OFS_IDENT_BYTE_SIX 12'hfd8

`define IRQ_LSB 4
`define IRQ_COUNT 4
`define BIT_FRAMING 7
`define BIT_RX_TIMEOUT 6
`define BIT_TX 5
`define BIT_RX 4

`define RESET_IRQ 4'h0
`define IDENT_DEFAULT 24'h5a3c96
`define ADDR_WIDTH 12

`endif

//--- rtl/irq_clear_pkg.sv
/*
  Types shared by the register bank.
  Assumes the constants header is on the include path.
*/
`include "irq_clear_consts.svh"
package irq_clear_pkg;
  typedef enum logic [1:0] {
    bus_idle,
    bus_access
  } bus_phase_t;
  typedef logic [`IRQ_COUNT-1:0] irq_vec_t;
endpackage

//--- rtl/irq_flag.sv
/*
  One sticky interrupt status bit with write-one-to-clear.
  Assumes set and clear are single-cycle strobes on sys_clk.
*/
`timescale 1ns/1ps
module irq_flag (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // async reset, low
  input wire logic set_pulse, // event
  input wire logic clear_pulse, // software clear
  output logic flag // sticky status
);
  logic flag_q;
  logic flag_d;

  // set wins over a same-cycle clear
  always_comb begin
    flag_d = flag_q;
    if (clear_pulse) begin
      flag_d = 1'b0;
    end
    if (set_pulse) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule

//--- rtl/irq_clear_regs.sv
/*
  Interrupt status, mask, clear and identification registers on APB.
  Assumes a synchronous APB master on sys_clk; event inputs are pulses.
*/
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "irq_clear_consts.svh"
module irq_clear_regs #(
  parameter logic [23:0] IDENT_VALUE = `IDENT_DEFAULT // arbitrary value
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst_b, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [3:0] irq_event, // rx, tx, rx_timeout, framing
  output logic [3:0] raw_status, // sticky raw status
  output logic [3:0] masked_status, // raw and mask
  output logic irq // level interrupt
);
  irq_clear_pkg::bus_phase_t phase_q;
  irq_clear_pkg::bus_phase_t phase_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;
  irq_clear_pkg::irq_vec_t mask_q;
  irq_clear_pkg::irq_vec_t mask_d;
  irq_clear_pkg::irq_vec_t clear_vec;
  irq_clear_pkg::irq_vec_t set_vec;
  irq_clear_pkg::irq_vec_t raw;
  logic wr_take;
  logic rd_take;
  logic mapped;

  // write taken in the first access cycle, read taken in setup; no wait states
  assign wr_take = psel && penable && pwrite &&
    (phase_q == irq_clear_pkg::bus_access);
  assign rd_take = psel && !penable;

  always_comb begin
    unique case (paddr)
      `OFS_RAW_STATUS, `OFS_MASK, `OFS_MASKED_STATUS,
      `OFS_INTERRUPT_CLEAR, `OFS_EVENT_SET,
      `OFS_IDENT_BYTE_FOUR, `OFS_IDENT_BYTE_FIVE,
      `OFS_IDENT_BYTE_SIX: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // bus phase: setup latches read data and error, access answers
  always_comb begin
    phase_d = phase_q;
    rdata_d = rdata_q;
    err_d = err_q;
    unique case (phase_q)
      irq_clear_pkg::bus_idle: begin
        if (rd_take) begin
          phase_d = irq_clear_pkg::bus_access;
          err_d = !mapped;
          rdata_d = 32'h0000_0000;
          if (!pwrite) begin
            unique case (paddr)
              `OFS_RAW_STATUS:
                rdata_d[`BIT_FRAMING:`IRQ_LSB] = raw;
              `OFS_MASK:
                rdata_d[`BIT_FRAMING:`IRQ_LSB] = mask_q;
              `OFS_MASKED_STATUS:
                rdata_d[`BIT_FRAMING:`IRQ_LSB] = raw & mask_q;
              `OFS_IDENT_BYTE_FOUR:
                rdata_d[7:0] = IDENT_VALUE[7:0]; // see [R6]
              `OFS_IDENT_BYTE_FIVE:
                rdata_d[7:0] = IDENT_VALUE[15:8]; // see [R6]
              `OFS_IDENT_BYTE_SIX:
                rdata_d[7:0] = IDENT_VALUE[23:16]; // see [R6]
              // clear register and reserved bits read zero, see [R8]
              default: rdata_d = 32'h0000_0000;
            endcase
          end
        end
      end
      irq_clear_pkg::bus_access: begin
        phase_d = irq_clear_pkg::bus_idle;
      end
    endcase
  end

  // mask register
  always_comb begin
    mask_d = mask_q;
    if (wr_take && !err_q && paddr == `OFS_MASK) begin
      mask_d = pwdata[`BIT_FRAMING:`IRQ_LSB];
    end
  end

  // one written to a clear bit clears that source unless its event sets it in the same cycle; zero does nothing
  always_comb begin
    clear_vec = '0;
    if (wr_take && !err_q && paddr == `OFS_INTERRUPT_CLEAR) begin // see [R8]
      clear_vec[`BIT_FRAMING-`IRQ_LSB] = pwdata[`BIT_FRAMING]; // see [R1]
      clear_vec[`BIT_RX_TIMEOUT-`IRQ_LSB] =
        pwdata[`BIT_RX_TIMEOUT]; // see [R2]
      clear_vec[`BIT_TX-`IRQ_LSB] = pwdata[`BIT_TX]; // see [R3]
      clear_vec[`BIT_RX-`IRQ_LSB] = pwdata[`BIT_RX]; // see [R4]
    end
  end

  // software test set, plus hardware events
  always_comb begin
    set_vec = irq_event;
    if (wr_take && !err_q && paddr == `OFS_EVENT_SET) begin
      set_vec = irq_event | pwdata[`BIT_FRAMING:`IRQ_LSB];
    end
  end

  // raw flag cleared; masked view follows since it is derived, see [R7]
  genvar i;
  generate
    for (i = 0; i < `IRQ_COUNT; i++) begin : g_flag
      irq_flag u_flag (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .set_pulse(set_vec[i]),
        .clear_pulse(clear_vec[i]),
        .flag(raw[i])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= irq_clear_pkg::bus_idle;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      mask_q <= `RESET_IRQ;
    end else begin
      phase_q <= phase_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      mask_q <= mask_d;
    end
  end

  assign pready = psel && penable && (phase_q == irq_clear_pkg::bus_access);
  assign pslverr = pready && err_q;
  assign prdata = rdata_q;
  assign raw_status = raw;
  assign masked_status = raw & mask_q; // see [R7]
  assign irq = |(raw & mask_q);
endmodule

//--- tb/irq_clear_assertions.sv
/* checker for the clear and ident bank ports.
   bound to every irq_clear_regs instance. */
`timescale 1ns/1ps
module irq_clear_assertions #(
  parameter logic [23:0] IDENT_VALUE = 24'h0 // arbitrary value
) (
  input wire logic sys_clk, // clk
  input wire logic rst_b, // rst
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [3:0] irq_event, // events
  input wire logic [3:0] raw_status, // raw
  input wire logic [3:0] masked_status, // masked
  input wire logic irq // irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic wr = psel && penable && pready && pwrite;
  wire logic rd = psel && penable && pready && !pwrite;
  wire logic clr = wr && paddr == 12'h044;
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  clr_framing_a: assert property (clr && pwdata[7] && !irq_event[3]
    |=> !raw_status[3]) else $error("framing flag kept");
  clr_rxto_a: assert property (clr && pwdata[6] && !irq_event[2]
    |=> !raw_status[2]) else $error("timeout flag kept");
  clr_tx_a: assert property (clr && pwdata[5] && !irq_event[1]
    |=> !raw_status[1]) else $error("tx flag kept");
  clr_rx_a: assert property (clr && pwdata[4] && !irq_event[0]
    |=> !raw_status[0]) else $error("rx flag kept");
  zero_keeps_a: assert property (clr |=>
    ((raw_status ^ $past(raw_status)) & ~$past(pwdata[7:4])
    & ~$past(irq_event)) == 4'h0) else $error("zero bit changed flag");
  masked_sub_a: assert property ((masked_status & ~raw_status) == 4'h0
    && irq == |masked_status) else $error("masked status stale");
  ident_read_a: assert property (rd && paddr inside {12'hfd0,
    12'hfd4, 12'hfd8} |-> prdata == {24'h0, IDENT_VALUE[8*paddr[3:2] +: 8]})
    else $error("ident read wrong");
  clr_zero_a: assert property (setup_s ##1 access_s |-> pready
    && (pwrite || paddr != 12'h044 || prdata == 32'h0))
    else $error("clear access wrong");
endmodule
bind irq_clear_regs irq_clear_assertions #(.IDENT_VALUE(IDENT_VALUE)) chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_event(irq_event),
  .raw_status(raw_status), .masked_status(masked_status), .irq(irq));

//--- tb/irq_clear_regs_tb.sv
/* bench for the clear and ident bank.
   drives apb and events, checks reads. */
`timescale 1ns/1ps
module irq_clear_regs_tb;
  localparam logic [23:0] IDENT = 24'h9c36a5; // arbitrary value
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq;
  logic [3:0] irq_event = 4'h0, raw_status, masked_status, raw = 4'h0, msk;
  logic [32:0] exp_q[$];
  logic [15:0] rnd = 16'h5ffd;
  int fail_count = 0, num_checks = 0, cyc = 0;
  irq_clear_regs #(.IDENT_VALUE(IDENT)) dut (.sys_clk(sys_clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_event(irq_event), .raw_status(raw_status),
    .masked_status(masked_status), .irq(irq));
  initial forever #5 sys_clk = ~sys_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH err_rdata exp %h seen %h", want, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    if (!w) exp_q.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, exp_q.pop_front());
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(0, 12'h044, 0, 33'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1, 12'hfd0 + 12'(4 * i), 32'hffffffff, 0);
      apb(0, 12'hfd0 + 12'(4 * i), 0, {25'h0, IDENT[8 * i +: 8]});
    end
    apb(0, 12'h100, 0, {1'b1, 32'h0});
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      msk = rnd[3:0];
      apb(1, 12'h038, {24'h0, msk, 4'h0}, 0);
      @(posedge sys_clk);
      irq_event <= rnd[7:4];
      raw = raw | rnd[7:4];
      @(posedge sys_clk);
      irq_event <= 4'h0;
      rnd = lfsr(rnd);
      apb(1, 12'h044, {rnd[15:8], rnd, rnd[7:0]}, 0);
      raw = raw & ~rnd[7:4];
      apb(0, 12'h03c, 0, {25'h0, raw, 4'h0});
      apb(0, 12'h040, 0, {25'h0, raw & msk, 4'h0});
      check({29'h0, raw_status}, {29'h0, raw});
      check({29'h0, masked_status}, {29'h0, raw & msk});
      check({32'h0, irq}, {32'h0, |(raw & msk)});
    end
    final_report();
  end
endmodule
